// >>> rtl/expansion_data_ram_map_consts.vh
// Constants for the expansion data RAM address map and register block.
// Assumes a single 100 MHz system clock and an AXI4-Lite register bus.
`ifndef EXPANSION_DATA_RAM_MAP_CONSTS_VH
`define EXPANSION_DATA_RAM_MAP_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_DATA_POINTER_HIGH 8'h00
`define OFS_DATA_POINTER_LOW 8'h04
`define OFS_EXPANSION_DATA_RAM_PAGE_SELECT 8'h08
`define OFS_INDEX_REGISTER_A 8'h0C
`define OFS_INDEX_REGISTER_B 8'h10
`define OFS_EXT_MEM_CONFIG 8'h14
`define OFS_FLASH_CONTROL 8'h18
`define OFS_MOVE_STATUS 8'h1C

// ****************************************
// Field positions and reset values
// ****************************************
`define CFG_FIFO_ENABLE_BIT 6
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_USED_MASK 8'h5F
`define CFG_RESET 8'h03
`define FLASH_WRITE_BIT 0
`define REG_RESET 8'h00

// ****************************************
// Memory modes
// ****************************************
`define MODE_ONCHIP_ONLY 2'h0
`define MODE_OFFCHIP_ONLY 2'h3

// ****************************************
// Address map
// ****************************************
`define FIFO_WINDOW_LO 16'h0400
`define FIFO_WINDOW_HI 16'h07FF
`define ONCHIP_BYTES_LARGE 16'h1000
`define ONCHIP_BYTES_SMALL 16'h0800
`define ONCHIP_MASK_LARGE 12'hFFF
`define ONCHIP_MASK_SMALL 12'h7FF

// ****************************************
// Move address sources
// ****************************************
`define SRC_DATA_POINTER 2'h0
`define SRC_INDEX_A 2'h1
`define SRC_INDEX_B 2'h2

// ****************************************
// Timing: least extra cycles for a FIFO window move
// ****************************************
`define FIFO_STRETCH_NS 20
`define CLK_PERIOD_NS 10
`define FIFO_STRETCH_CYCLES ((`FIFO_STRETCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Target codes shown in status
// ****************************************
`define TGT_ONCHIP 2'h0
`define TGT_FIFO 2'h1
`define TGT_EXTERNAL 2'h2
`define TGT_FLASH 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> rtl/expansion_data_ram_bank.v
// On-chip expansion data RAM storage, one byte per location.
// Assumes the caller masks the address to the fitted size; read data lags one cycle.
`timescale 1ns/100ps
module expansion_data_ram_bank (
  input wire aclk,
  input wire en,
  input wire we,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);

  // Storage array; no reset so it maps onto block RAM
  reg [7:0] mem [0:4095];

  // Synchronous read and write port
  always @(posedge aclk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule

// >>> rtl/expansion_data_ram_address_and_fifo_map.v
// Address generation and decode for external data moves of the core.
// Assumes move_start only while move_busy is low; far ports answer on aclk.
// Behaviour
// (RL1) On-chip RAM of 4 KB or 2 KB mapped
// (RL2) Pointer form uses full 16-bit data pointer
// (RL3) Data pointer as two writable byte registers
// (RL4) Short form: page-select high, index register low
// (RL5) Moves target expansion RAM unless flash writing
// (RL6) USB FIFO RAM mappable into expansion space
// (RL7) Enable maps 0x0400-0x07FF to FIFO RAM
// (RL8) Overlapped normal memory inaccessible while enabled
// (RL9) Software enables access, USB clock two-fold
// (RL10) FIFO RAM clocked by running USB clock
// (RL11) FIFO window moves take extra cycles
// (RL12) Packet data uses FIFO registers, not moves
// (RL13) External interface reaches off-chip memories
// (RL14) Window goes to normal memory when disabled
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "expansion_data_ram_map_consts.vh"
module expansion_data_ram_address_and_fifo_map #(
  parameter small_variant = 0,
  parameter has_external_interface = 1
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite register slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core side external moves
  input wire move_start,
  input wire move_write,
  input wire [1:0] move_source,
  input wire [7:0] move_wdata,
  output reg [7:0] move_rdata,
  output reg move_done,
  output reg move_busy,
  // USB FIFO RAM port
  output reg fifo_req,
  output reg fifo_we,
  output reg [9:0] fifo_addr,
  output reg [7:0] fifo_wdata,
  input wire [7:0] fifo_rdata,
  input wire fifo_ack,
  // External memory interface port
  output reg external_memory_interface_req,
  output reg external_memory_interface_we,
  output reg [15:0] external_memory_interface_addr,
  output reg [7:0] external_memory_interface_wdata,
  input wire [7:0] external_memory_interface_rdata,
  input wire external_memory_interface_ack,
  // Flash write port
  output reg flash_wr,
  output reg [15:0] flash_addr,
  output reg [7:0] flash_wdata
);

  // ****************************************
  // Registers and state
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_RAM = 3'h1;
  localparam ST_FIFO = 3'h2;
  localparam ST_EXTERNAL_MEMORY_INTERFACE = 3'h3;
  localparam ST_DONE = 3'h4;
  reg [7:0] data_pointer_high;
  reg [7:0] data_pointer_low;
  reg [7:0] expansion_data_ram_page_select;
  reg [7:0] index_register_a;
  reg [7:0] index_register_b;
  reg [7:0] ext_mem_config;
  reg flash_write_enable;
  reg [2:0] state;
  reg [1:0] last_target;
  reg [1:0] stretch_count;
  reg fifo_seen;
  reg ram_en;
  reg ram_we;
  reg [11:0] ram_addr;
  reg [7:0] ram_wdata;
  wire [7:0] ram_rdata;
  // ****************************************
  // Address formation and decode
  // ****************************************
  reg [15:0] eff_addr;
  reg [7:0] low_byte;
  reg [1:0] next_target;
  wire usb_fifo_access_enable = ext_mem_config[`CFG_FIFO_ENABLE_BIT];
  wire [1:0] mem_mode = ext_mem_config[`CFG_MODE_HI:`CFG_MODE_LO];
  wire [15:0] onchip_top = small_variant ? `ONCHIP_BYTES_SMALL : `ONCHIP_BYTES_LARGE;
  wire [11:0] onchip_mask = small_variant ? `ONCHIP_MASK_SMALL : `ONCHIP_MASK_LARGE;
  wire in_window = (eff_addr >= `FIFO_WINDOW_LO) && (eff_addr <= `FIFO_WINDOW_HI);
  // Pick the effective address and the target of a move
  always @* begin
    low_byte = (move_source == `SRC_INDEX_B) ? index_register_b : index_register_a;
    if (move_source == `SRC_DATA_POINTER) begin
      eff_addr = {data_pointer_high, data_pointer_low}; // see RL2
    end else begin
      eff_addr = {expansion_data_ram_page_select, low_byte}; // see RL4
    end
    if (move_write && flash_write_enable) begin
      next_target = `TGT_FLASH; // see RL5
    end else if (usb_fifo_access_enable && in_window) begin
      next_target = `TGT_FIFO; // see RL7 see RL8 see RL6
    end else if (has_external_interface != 0 && (mem_mode == `MODE_OFFCHIP_ONLY ||
        (mem_mode != `MODE_ONCHIP_ONLY && eff_addr >= onchip_top))) begin
      next_target = `TGT_EXTERNAL; // see RL13
    end else begin
      next_target = `TGT_ONCHIP; // see RL14 see RL1
    end
  end
  // On-chip storage; upper bits alias onto the fitted size
  expansion_data_ram_bank i_expansion_data_ram_bank (
    .aclk(aclk),
    .en(ram_en),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // ****************************************
  // Move sequencer
  // ****************************************
  // FIFO moves wait for the answer and a least stretch: that RAM answers late
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      move_done <= 1'b0;
      move_busy <= 1'b0;
      move_rdata <= 8'h00;
      last_target <= `TGT_ONCHIP;
      stretch_count <= 2'h0;
      fifo_seen <= 1'b0;
      ram_en <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= 12'h000;
      ram_wdata <= 8'h00;
      fifo_req <= 1'b0;
      fifo_we <= 1'b0;
      fifo_addr <= 10'h000;
      fifo_wdata <= 8'h00;
      external_memory_interface_req <= 1'b0;
      external_memory_interface_we <= 1'b0;
      external_memory_interface_addr <= 16'h0000;
      external_memory_interface_wdata <= 8'h00;
      flash_wr <= 1'b0;
      flash_addr <= 16'h0000;
      flash_wdata <= 8'h00;
    end else begin
      move_done <= 1'b0;
      ram_en <= 1'b0;
      flash_wr <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (move_start) begin
            move_busy <= 1'b1;
            last_target <= next_target;
            if (next_target == `TGT_FLASH) begin
              flash_wr <= 1'b1; // see RL5
              flash_addr <= eff_addr;
              flash_wdata <= move_wdata;
              state <= ST_DONE;
            end else if (next_target == `TGT_FIFO) begin
              fifo_req <= 1'b1; // see RL10
              fifo_we <= move_write;
              fifo_addr <= eff_addr[9:0];
              fifo_wdata <= move_wdata;
              stretch_count <= 2'h0;
              fifo_seen <= 1'b0;
              state <= ST_FIFO;
            end else if (next_target == `TGT_EXTERNAL) begin
              external_memory_interface_req <= 1'b1; // see RL13
              external_memory_interface_we <= move_write;
              external_memory_interface_addr <= eff_addr;
              external_memory_interface_wdata <= move_wdata;
              state <= ST_EXTERNAL_MEMORY_INTERFACE;
            end else begin
              ram_en <= 1'b1; // see RL1
              ram_we <= move_write;
              ram_addr <= eff_addr[11:0] & onchip_mask;
              ram_wdata <= move_wdata;
              state <= ST_RAM;
            end
          end
        end
        ST_RAM: begin
          state <= ST_DONE;
        end
        ST_FIFO: begin
          if (stretch_count != 2'h3) begin
            stretch_count <= stretch_count + 2'h1;
          end
          if (fifo_ack) begin
            fifo_req <= 1'b0;
            fifo_seen <= 1'b1;
            move_rdata <= fifo_rdata;
          end
          if ((fifo_ack || fifo_seen) && stretch_count >= `FIFO_STRETCH_CYCLES) begin
            state <= ST_DONE; // see RL11
          end
        end
        ST_EXTERNAL_MEMORY_INTERFACE: begin
          if (external_memory_interface_ack) begin
            external_memory_interface_req <= 1'b0;
            move_rdata <= external_memory_interface_rdata;
            state <= ST_DONE;
          end
        end
        default: begin
          if (last_target == `TGT_ONCHIP && !ram_we) move_rdata <= ram_rdata; // Bank lags
          move_done <= 1'b1;
          move_busy <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire lane0 = s_axi_wstrb[0];
  wire [7:0] wbyte = s_axi_wdata[7:0];
  // Address and data taken together; one write in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      data_pointer_high <= `REG_RESET;
      data_pointer_low <= `REG_RESET;
      expansion_data_ram_page_select <= `REG_RESET;
      index_register_a <= `REG_RESET;
      index_register_b <= `REG_RESET;
      ext_mem_config <= `CFG_RESET;
      flash_write_enable <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (s_axi_awaddr == `OFS_DATA_POINTER_HIGH) begin
          if (lane0) data_pointer_high <= wbyte; // see RL3
        end else if (s_axi_awaddr == `OFS_DATA_POINTER_LOW) begin
          if (lane0) data_pointer_low <= wbyte; // see RL3
        end else if (s_axi_awaddr == `OFS_EXPANSION_DATA_RAM_PAGE_SELECT) begin
          if (lane0) expansion_data_ram_page_select <= wbyte;
        end else if (s_axi_awaddr == `OFS_INDEX_REGISTER_A) begin
          if (lane0) index_register_a <= wbyte;
        end else if (s_axi_awaddr == `OFS_INDEX_REGISTER_B) begin
          if (lane0) index_register_b <= wbyte;
        end else if (s_axi_awaddr == `OFS_EXT_MEM_CONFIG) begin
          // Software sets the FIFO enable before window moves
          if (lane0) ext_mem_config <= wbyte & `CFG_USED_MASK; // see RL9
        end else if (s_axi_awaddr == `OFS_FLASH_CONTROL) begin
          if (lane0) flash_write_enable <= wbyte[`FLASH_WRITE_BIT];
        end else if (s_axi_awaddr != `OFS_MOVE_STATUS) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  reg [7:0] rd_byte;
  reg rd_ok;
  // Read decode; status shows sequencer state and last target
  always @* begin
    rd_ok = 1'b1;
    rd_byte = 8'h00;
    if (s_axi_araddr == `OFS_DATA_POINTER_HIGH) begin
      rd_byte = data_pointer_high;
    end else if (s_axi_araddr == `OFS_DATA_POINTER_LOW) begin
      rd_byte = data_pointer_low;
    end else if (s_axi_araddr == `OFS_EXPANSION_DATA_RAM_PAGE_SELECT) begin
      rd_byte = expansion_data_ram_page_select;
    end else if (s_axi_araddr == `OFS_INDEX_REGISTER_A) begin
      rd_byte = index_register_a;
    end else if (s_axi_araddr == `OFS_INDEX_REGISTER_B) begin
      rd_byte = index_register_b;
    end else if (s_axi_araddr == `OFS_EXT_MEM_CONFIG) begin
      rd_byte = ext_mem_config;
    end else if (s_axi_araddr == `OFS_FLASH_CONTROL) begin
      rd_byte = {7'h00, flash_write_enable};
    end else if (s_axi_araddr == `OFS_MOVE_STATUS) begin
      rd_byte = {3'h0, last_target, state};
    end else begin
      rd_ok = 1'b0;
    end
  end
  // One read in flight; data held until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end
endmodule

// >>> verification/expansion_data_ram_map_sva.sv
// Concurrent checks on the address map block's ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module expansion_data_ram_map_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire move_start,
  input wire move_busy,
  input wire move_done,
  input wire fifo_req,
  input wire fifo_ack,
  input wire [9:0] fifo_addr,
  input wire external_memory_interface_req,
  input wire external_memory_interface_ack,
  input wire [15:0] external_memory_interface_addr,
  input wire flash_wr
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Busy must show one edge after an accepted start
  busy_on_start_a: assert property (move_start && !move_busy |=> move_busy)
    else $error("move not taken");
  done_single_a: assert property (move_done |=> !move_done)
    else $error("done longer than one cycle");
  // A window move can never finish in on-chip time
  fifo_stretch_a: assert property ($rose(fifo_req) |-> !move_done [*3])
    else $error("fifo move not stretched");
  fifo_hold_a: assert property (fifo_req && !fifo_ack |=> fifo_req && $stable(fifo_addr))
    else $error("fifo request dropped early");
  fifo_release_a: assert property (fifo_ack |=> !fifo_req)
    else $error("fifo request held after ack");
  one_target_a: assert property (!(fifo_req && external_memory_interface_req) &&
      !(flash_wr && (fifo_req || external_memory_interface_req)))
    else $error("two targets at once");
  external_memory_interface_hold_a: assert property (external_memory_interface_req && !external_memory_interface_ack |=> external_memory_interface_req && $stable(external_memory_interface_addr))
    else $error("external request dropped early");
  req_in_move_a: assert property (fifo_req || external_memory_interface_req |-> move_busy)
    else $error("memory request outside a move");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  // Main scenarios reached
  cover property (fifo_ack);
  cover property (external_memory_interface_ack);
  cover property (flash_wr);
  cover property (move_done);
endmodule

bind expansion_data_ram_address_and_fifo_map expansion_data_ram_map_sva i_expansion_data_ram_map_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .move_start(move_start),
  .move_busy(move_busy), .move_done(move_done), .fifo_req(fifo_req), .fifo_ack(fifo_ack),
  .fifo_addr(fifo_addr), .external_memory_interface_req(external_memory_interface_req), .external_memory_interface_ack(external_memory_interface_ack), .external_memory_interface_addr(external_memory_interface_addr),
  .flash_wr(flash_wr));

// >>> verification/expansion_data_ram_far_side.sv
// Model of the FIFO RAM and the off-chip memory behind the map block.
// Assumes requests are held until ack; rdata toggles when not answering.
`timescale 1ns/100ps
module expansion_data_ram_far_side #(
  parameter fifo_wait = 3,
  parameter external_memory_interface_wait = 1
) (
  input wire aclk,
  input wire fifo_req,
  input wire fifo_we,
  input wire [9:0] fifo_addr,
  input wire [7:0] fifo_wdata,
  output reg [7:0] fifo_rdata,
  output reg fifo_ack,
  input wire external_memory_interface_req,
  input wire external_memory_interface_we,
  input wire [15:0] external_memory_interface_addr,
  input wire [7:0] external_memory_interface_wdata,
  output reg [7:0] external_memory_interface_rdata,
  output reg external_memory_interface_ack
);
  reg [7:0] fifo_mem [0:1023];
  reg [7:0] external_memory_interface_mem [0:65535];
  integer fc = 0;
  integer ec = 0;
  initial begin
    fifo_ack = 1'b0;
    external_memory_interface_ack = 1'b0;
    fifo_rdata = 8'h00;
    external_memory_interface_rdata = 8'h00;
  end
  // ****************************************
  // Responders
  // ****************************************
  // Slow FIFO answer; USB clock taken as running at twice the rate
  always @(posedge aclk) begin
    fifo_ack <= 1'b0;
    fifo_rdata <= ~fifo_rdata; // No stale byte outside an answer
    fc = (fifo_req && !fifo_ack) ? fc + 1 : 0;
    if (fc >= fifo_wait) begin
      fc = 0;
      fifo_ack <= 1'b1;
      if (fifo_we) fifo_mem[fifo_addr] <= fifo_wdata;
      else fifo_rdata <= fifo_mem[fifo_addr];
    end
  end
  // Prompt off-chip memory
  always @(posedge aclk) begin
    external_memory_interface_ack <= 1'b0;
    external_memory_interface_rdata <= ~external_memory_interface_rdata;
    ec = (external_memory_interface_req && !external_memory_interface_ack) ? ec + 1 : 0;
    if (ec >= external_memory_interface_wait) begin
      ec = 0;
      external_memory_interface_ack <= 1'b1;
      if (external_memory_interface_we) external_memory_interface_mem[external_memory_interface_addr] <= external_memory_interface_wdata;
      else external_memory_interface_rdata <= external_memory_interface_mem[external_memory_interface_addr];
    end
  end
endmodule

// >>> verification/expansion_data_ram_address_and_fifo_map_tb.sv
// Bench for the address map: register tasks over AXI4-Lite, move tasks as the core.
// Assumes the far-side model answers FIFO and off-chip requests.
`timescale 1ns/100ps
`include "expansion_data_ram_map_consts.vh"
module expansion_data_ram_address_and_fifo_map_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, mwdata = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg mstart = 1'b0, mwrite = 1'b0;
  reg [1:0] msrc = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, move_done, move_busy;
  wire fifo_req, fifo_we, fifo_ack, external_memory_interface_req, external_memory_interface_we, external_memory_interface_ack, flash_wr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] move_rdata, fifo_rdata, external_memory_interface_rdata, fifo_wdata, external_memory_interface_wdata, flash_wdata;
  wire [9:0] fifo_addr;
  wire [15:0] external_memory_interface_addr, flash_addr;
  reg [15:0] fl_addr = 16'h0;
  reg [7:0] fl_data = 8'h00, b;
  reg [31:0] d;
  reg [1:0] r;
  integer miscompares = 0, cmp_count = 0, n, n_on;
  always #5 aclk = ~aclk;
  expansion_data_ram_address_and_fifo_map i_expansion_data_ram_address_and_fifo_map (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .move_start(mstart), .move_write(mwrite),
    .move_source(msrc), .move_wdata(mwdata), .move_rdata(move_rdata), .move_done(move_done),
    .move_busy(move_busy), .fifo_req(fifo_req), .fifo_we(fifo_we), .fifo_addr(fifo_addr),
    .fifo_wdata(fifo_wdata), .fifo_rdata(fifo_rdata), .fifo_ack(fifo_ack),
    .external_memory_interface_req(external_memory_interface_req), .external_memory_interface_we(external_memory_interface_we), .external_memory_interface_addr(external_memory_interface_addr), .external_memory_interface_wdata(external_memory_interface_wdata),
    .external_memory_interface_rdata(external_memory_interface_rdata), .external_memory_interface_ack(external_memory_interface_ack), .flash_wr(flash_wr),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata));
  expansion_data_ram_far_side i_expansion_data_ram_far_side (.aclk(aclk), .fifo_req(fifo_req), .fifo_we(fifo_we),
    .fifo_addr(fifo_addr), .fifo_wdata(fifo_wdata), .fifo_rdata(fifo_rdata),
    .fifo_ack(fifo_ack), .external_memory_interface_req(external_memory_interface_req), .external_memory_interface_we(external_memory_interface_we), .external_memory_interface_addr(external_memory_interface_addr),
    .external_memory_interface_wdata(external_memory_interface_wdata), .external_memory_interface_rdata(external_memory_interface_rdata), .external_memory_interface_ack(external_memory_interface_ack));
  // Catch the flash pulse; it stands one cycle only
  always @(posedge aclk) begin
    if (flash_wr === 1'b1) begin
      fl_addr <= flash_addr;
      fl_data <= flash_wdata;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task wrap_up;
    begin
      $display("Checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task chk(input [79:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task hang;
    begin
      miscompares = miscompares + 1;
      $display("BAD wait expected answer seen none");
      wrap_up;
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] v);
    integer i;
    reg ok;
    begin
      ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40 && !ok; i = i + 1) begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
          ok = 1'b1;
          r = bresp;
          bready <= 1'b0;
        end
      end
      if (!ok) hang;
    end
  endtask
  task axi_rd(input [7:0] a);
    integer i;
    reg ok;
    begin
      ok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40 && !ok; i = i + 1) begin
        @(posedge aclk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) begin
          ok = 1'b1;
          d = rdata;
          r = rresp;
          rready <= 1'b0;
        end
      end
      if (!ok) hang;
    end
  endtask
  task set_dp(input [15:0] a);
    begin
      axi_wr(`OFS_DATA_POINTER_HIGH, {24'h0, a[15:8]});
      axi_wr(`OFS_DATA_POINTER_LOW, {24'h0, a[7:0]});
    end
  endtask
  // One move as the core makes it; n counts edges until done is seen
  task mv(input w, input [1:0] s, input [7:0] v);
    integer i;
    reg ok;
    begin
      ok = 1'b0;
      @(posedge aclk);
      mstart <= 1'b1;
      mwrite <= w;
      msrc <= s;
      mwdata <= v;
      @(posedge aclk);
      mstart <= 1'b0;
      for (n = 0; n < 40 && !ok; n = n + 1) begin
        @(posedge aclk);
        if (move_done === 1'b1) begin
          ok = 1'b1;
          b = move_rdata;
        end
      end
      if (!ok) hang;
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`OFS_EXT_MEM_CONFIG);
    chk("cfg_reset", {24'h0, `CFG_RESET}, d);
    axi_rd(8'h20);
    chk("unmapped", `RESP_SLVERR, r);
    axi_wr(8'h20, 32'h0);
    chk("wr_unmap", `RESP_SLVERR, r);
    set_dp(16'h0123);
    axi_rd(`OFS_DATA_POINTER_HIGH);
    chk("dp_high", 32'h01, d);
    mv(1'b1, `SRC_DATA_POINTER, 8'hA5);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    n_on = n;
    chk("dp_move", 8'hA5, b);
    axi_wr(`OFS_EXPANSION_DATA_RAM_PAGE_SELECT, 32'h01);
    axi_wr(`OFS_INDEX_REGISTER_A, 32'h23);
    axi_wr(`OFS_INDEX_REGISTER_B, 32'h23);
    mv(1'b0, `SRC_INDEX_A, 8'h00);
    chk("idx_a", 8'hA5, b);
    // Index a now points elsewhere, so source b must use its own register
    axi_wr(`OFS_INDEX_REGISTER_A, 32'h00);
    mv(1'b0, `SRC_INDEX_B, 8'h00);
    chk("idx_b", 8'hA5, b);
    set_dp(16'h1123);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("alias_4k", 8'hA5, b);
    set_dp(16'h0456);
    mv(1'b1, `SRC_DATA_POINTER, 8'h77);
    axi_wr(`OFS_EXT_MEM_CONFIG, 32'h43);
    // Spare window byte only, never packet data
    mv(1'b1, `SRC_DATA_POINTER, 8'h3C);
    chk("fifo_wr", 8'h3C, i_expansion_data_ram_far_side.fifo_mem[10'h056]);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("fifo_rd", 8'h3C, b);
    chk("stretch", 1, n > n_on);
    set_dp(16'h0123);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("outside", 8'hA5, b);
    axi_wr(`OFS_EXT_MEM_CONFIG, 32'h03);
    set_dp(16'h0456);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("win_off", 8'h77, b);
    axi_wr(`OFS_EXT_MEM_CONFIG, 32'h0F);
    set_dp(16'h1234);
    mv(1'b1, `SRC_DATA_POINTER, 8'h5A);
    chk("external_memory_interface_wr", 8'h5A, i_expansion_data_ram_far_side.external_memory_interface_mem[16'h1234]);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("external_memory_interface_rd", 8'h5A, b);
    axi_wr(`OFS_EXT_MEM_CONFIG, 32'h07);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("split_hi", 8'h5A, b);
    axi_wr(`OFS_EXT_MEM_CONFIG, 32'h03);
    axi_wr(`OFS_FLASH_CONTROL, 32'h01);
    set_dp(16'h0123);
    mv(1'b1, `SRC_DATA_POINTER, 8'h99);
    chk("fl_addr", 16'h0123, fl_addr);
    chk("fl_data", 8'h99, fl_data);
    axi_rd(`OFS_MOVE_STATUS);
    chk("status", {27'h0, `TGT_FLASH, 3'h0}, d);
    mv(1'b0, `SRC_DATA_POINTER, 8'h00);
    chk("fl_read", 8'hA5, b);
    wrap_up;
  end
endmodule
